// ### pkg/sps_defines.svh
`ifndef SPS_DEFINES_SVH
`define SPS_DEFINES_SVH

`define SPS_IDX_CFG5 8'h25
`define SPS_IDX_REV 8'h27
`define SPS_IDX_SMIEN 8'h28
`define SPS_IDX_PINFN 8'h2A
`define SPS_IDX_STAT 8'h30
`define SPS_IDX_MASK 8'h31
`define SPS_CFG5_IRQ2_BIT 5
`define SPS_CFG5_FAN_LO 0
`define SPS_CFG5_WMASK 8'h23
`define SPS_PINFN_STRAP_BIT 7
`define SPS_PINFN_CHAS_BIT 6
`define SPS_PINFN_P27_LO 4
`define SPS_PINFN_LED_DRIVE_SECOND_BIT 3
`define SPS_PINFN_P25_LO 1
`define SPS_PINFN_OVERTEMP_OUT_FIRST_BIT 0
`define SPS_PINFN_WMASK 8'h7F
`define SPS_RESET_BYTE 8'h00
`define SPS_REV_DEFAULT 8'h01

`endif

// ### pkg/sps_pkg.sv
package sps_pkg;
    typedef enum logic [1:0] {
        SPS_FAN_GPIO = 2'h0,
        SPS_FAN_TACH = 2'h1
    } sps_fan_sel_type;
    typedef enum logic [1:0] {
        SPS_P27_GPIO = 2'h0,
        SPS_P27_RING = 2'h1,
        SPS_P27_ALARM = 2'h2
    } sps_p27_sel_type;
    typedef enum logic [1:0] {
        SPS_P25_GPIO = 2'h0,
        SPS_P25_LED_DRIVE_FIRST = 2'h1,
        SPS_P25_OVERTEMP_OUT_SECOND = 2'h2
    } sps_p25_sel_type;
endpackage

// ### rtl/sps_pin_select.sv
`timescale 1ns/1ps
`default_nettype none
`include "sps_defines.svh"

// Functional notes
// - Interrupt-line-two enable bit, read-write, cleared at reset, mirrors management interrupt.
// - Two-bit pin select: 00 general IO, 01 fan tach two, others reserved.
// - Read-only revision register at index 27h; writes ignored.
// - Enable bits 7,6,5 gate voltage, temperature and chassis events; reset zero.
// - Enable bit 4 gates mouse, bit 3 keyboard interrupt into management interrupt.
// - Bits 2,1,0 gate keyboard port line two, general inputs, watchdog.
// - Pin function register at 2Ah keeps contents; defaults only at battery reset.
// - Bit 7 read-only, latched from two straps at standby power-up.
// - Bit 6 selects battery IO line 5 or chassis intrusion output.
// - Bits 5-4: 00 general IO, 01 ring input, 10 alarm.
// - Bit 3 selects battery IO line 3 or second LED output.
// - Bits 2-1: 00 IO, 01 first LED, 10 second overtemp only with first.
// - Bit 0 selects battery IO line 1 or first overtemp output.
// - Only first overtemp output: any of four sources activates it.
// - Both outputs: remote two drives second; others drive first only.
module sps_pin_select #(
    parameter logic [7:0] REVISION = `SPS_REV_DEFAULT // Arbitrary value.
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic nbat_rst,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [7:0] rdata,
    input wire logic [1:0] power_control_straps,
    input wire logic voltage_monitor,
    input wire logic temp_event,
    input wire logic chassis_intrusion_out,
    input wire logic mouse_irq,
    input wire logic keyboard_irq,
    input wire logic keyboard_port_one_line_two,
    input wire logic general_input_events,
    input wire logic watchdog_output,
    input wire logic ot_remote_one,
    input wire logic ot_remote_two,
    input wire logic ot_local,
    input wire logic ot_voltage,
    output logic system_management_interrupt,
    output logic irq2_out,
    output logic irq,
    output logic [1:0] fan_pin_sel,
    output logic standby_pins_analog,
    output logic chassis_pin_sel,
    output logic [1:0] ring_pin_sel,
    output logic led_drive_second_pin_sel,
    output logic [1:0] led_drive_first_pin_sel,
    output logic overtemp_out_first_pin_sel,
    output logic overtemp_out_first,
    output logic overtemp_out_second
);
    logic rst_s1, rst_s2;
    logic bat_s1, bat_s2;
    logic [7:0] src_s1, src_s2;
    logic [3:0] ot_s1, ot_s2;
    logic [1:0] strap_s1, strap_s2;
    logic [1:0] strap_age;
    logic strap_taken;
    logic [7:0] cfg5;
    logic [7:0] smien;
    logic [6:0] pinfn;
    logic strap_bit;
    logic [7:0] status;
    logic [7:0] mask;
    logic [7:0] src_raw;
    logic [7:0] gated;
    logic overtemp_out_first_en, overtemp_out_second_en;
    logic next_ot1, next_ot2;
    logic [7:0] next_rdata;
    logic stat_rd;

    assign src_raw = {voltage_monitor, temp_event, chassis_intrusion_out, mouse_irq,
                      keyboard_irq, keyboard_port_one_line_two, general_input_events,
                      watchdog_output};

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rst_s1 <= 1'b0;
            rst_s2 <= 1'b0;
        end else begin
            rst_s1 <= 1'b1;
            rst_s2 <= rst_s1;
        end
    end

    // Battery-domain reset gets its own synchroniser.
    always_ff @(posedge clk or negedge nbat_rst) begin
        if (!nbat_rst) begin
            bat_s1 <= 1'b0;
            bat_s2 <= 1'b0;
        end else begin
            bat_s1 <= 1'b1;
            bat_s2 <= bat_s1;
        end
    end

    always_ff @(posedge clk or negedge rst_s2) begin
        if (!rst_s2) begin
            src_s1 <= `SPS_RESET_BYTE;
            src_s2 <= `SPS_RESET_BYTE;
            ot_s1 <= 4'h0;
            ot_s2 <= 4'h0;
        end else begin
            src_s1 <= src_raw;
            src_s2 <= src_s1;
            ot_s1 <= {ot_voltage, ot_local, ot_remote_two, ot_remote_one};
            ot_s2 <= ot_s1;
        end
    end

    // The strap synchroniser lives in the standby domain; the age bits mark when its
    // second stage holds a real pin sample rather than the reset value.
    always_ff @(posedge clk or negedge bat_s2) begin
        if (!bat_s2) begin
            strap_s1 <= 2'h0;
            strap_s2 <= 2'h0;
            strap_age <= 2'h0;
        end else begin
            strap_s1 <= power_control_straps;
            strap_s2 <= strap_s1;
            strap_age <= {strap_age[0], 1'b1};
        end
    end

    // Straps are caught once after standby release; power control off means analog set.
    always_ff @(posedge clk or negedge bat_s2) begin
        if (!bat_s2) begin
            strap_taken <= 1'b0;
            strap_bit <= 1'b0;
        end else if (!strap_taken && strap_age[1] && rst_s2) begin
            strap_taken <= 1'b1;
            strap_bit <= &strap_s2;
        end
    end

    always_ff @(posedge clk or negedge rst_s2) begin
        if (!rst_s2) begin
            cfg5 <= `SPS_RESET_BYTE;
        end else if (wr && addr == `SPS_IDX_CFG5) begin
            cfg5 <= wdata & `SPS_CFG5_WMASK;
        end
    end

    always_ff @(posedge clk or negedge rst_s2) begin
        if (!rst_s2) begin
            smien <= `SPS_RESET_BYTE;
        end else if (wr && addr == `SPS_IDX_SMIEN) begin
            smien <= wdata;
        end
    end

    // Held by the battery reset only, so main reset leaves it intact.
    always_ff @(posedge clk or negedge bat_s2) begin
        if (!bat_s2) begin
            pinfn <= 7'h00;
        end else if (wr && rst_s2 && addr == `SPS_IDX_PINFN) begin
            pinfn <= wdata[6:0];
        end
    end

    always_ff @(posedge clk or negedge rst_s2) begin
        if (!rst_s2) begin
            mask <= `SPS_RESET_BYTE;
        end else if (wr && addr == `SPS_IDX_MASK) begin
            mask <= wdata;
        end
    end

    assign gated = src_s2 & smien;
    assign stat_rd = rd && addr == `SPS_IDX_STAT;

    // New events win over the clearing read.
    always_ff @(posedge clk or negedge rst_s2) begin
        if (!rst_s2) begin
            status <= `SPS_RESET_BYTE;
        end else if (stat_rd) begin
            status <= gated;
        end else begin
            status <= status | gated;
        end
    end

    always_ff @(posedge clk or negedge rst_s2) begin
        if (!rst_s2) begin
            system_management_interrupt <= 1'b0;
            irq2_out <= 1'b0;
            irq <= 1'b0;
        end else begin
            system_management_interrupt <= |gated;
            irq2_out <= (|gated) & cfg5[`SPS_CFG5_IRQ2_BIT];
            irq <= |(status & mask);
        end
    end

    assign overtemp_out_first_en = pinfn[`SPS_PINFN_OVERTEMP_OUT_FIRST_BIT];
    assign overtemp_out_second_en = overtemp_out_first_en &&
        pinfn[`SPS_PINFN_P25_LO +: 2] == sps_pkg::SPS_P25_OVERTEMP_OUT_SECOND;

    always_comb begin
        next_ot1 = 1'b0;
        next_ot2 = 1'b0;
        if (overtemp_out_second_en) begin
            next_ot1 = ot_s2[0] | ot_s2[2] | ot_s2[3];
            next_ot2 = ot_s2[1];
        end else if (overtemp_out_first_en) begin
            next_ot1 = |ot_s2;
        end
    end

    always_ff @(posedge clk or negedge rst_s2) begin
        if (!rst_s2) begin
            overtemp_out_first <= 1'b0;
            overtemp_out_second <= 1'b0;
        end else begin
            overtemp_out_first <= next_ot1;
            overtemp_out_second <= next_ot2;
        end
    end

    always_ff @(posedge clk or negedge rst_s2) begin
        if (!rst_s2) begin
            fan_pin_sel <= 2'h0;
            standby_pins_analog <= 1'b0;
            chassis_pin_sel <= 1'b0;
            ring_pin_sel <= 2'h0;
            led_drive_second_pin_sel <= 1'b0;
            led_drive_first_pin_sel <= 2'h0;
            overtemp_out_first_pin_sel <= 1'b0;
        end else begin
            fan_pin_sel <= cfg5[`SPS_CFG5_FAN_LO +: 2];
            standby_pins_analog <= strap_bit;
            chassis_pin_sel <= pinfn[`SPS_PINFN_CHAS_BIT];
            ring_pin_sel <= pinfn[`SPS_PINFN_P27_LO +: 2];
            led_drive_second_pin_sel <= pinfn[`SPS_PINFN_LED_DRIVE_SECOND_BIT];
            led_drive_first_pin_sel <= overtemp_out_second_en ? sps_pkg::SPS_P25_OVERTEMP_OUT_SECOND :
                (pinfn[`SPS_PINFN_P25_LO +: 2] == sps_pkg::SPS_P25_OVERTEMP_OUT_SECOND ?
                 sps_pkg::SPS_P25_GPIO : pinfn[`SPS_PINFN_P25_LO +: 2]);
            overtemp_out_first_pin_sel <= overtemp_out_first_en;
        end
    end

    always_comb begin
        case (addr)
            `SPS_IDX_CFG5: next_rdata = cfg5;
            `SPS_IDX_REV: next_rdata = REVISION;
            `SPS_IDX_SMIEN: next_rdata = smien;
            `SPS_IDX_PINFN: next_rdata = {strap_bit, pinfn};
            `SPS_IDX_STAT: next_rdata = status;
            `SPS_IDX_MASK: next_rdata = mask;
            default: next_rdata = `SPS_RESET_BYTE;
        endcase
    end

    always_ff @(posedge clk or negedge rst_s2) begin
        if (!rst_s2) begin
            rdata <= `SPS_RESET_BYTE;
        end else if (rd) begin
            rdata <= next_rdata;
        end else begin
            rdata <= `SPS_RESET_BYTE;
        end
    end
endmodule

`default_nettype wire

// ### testbench/sps_pin_select_properties.sv
`timescale 1ns/1ps
`default_nettype none
`include "sps_defines.svh"
module sps_pin_select_properties #(
    parameter logic [7:0] REVISION = `SPS_REV_DEFAULT
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic nbat_rst,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    input wire logic [7:0] rdata,
    input wire logic system_management_interrupt,
    input wire logic irq2_out,
    input wire logic [1:0] fan_pin_sel,
    input wire logic chassis_pin_sel,
    input wire logic [1:0] ring_pin_sel,
    input wire logic led_drive_second_pin_sel,
    input wire logic [1:0] led_drive_first_pin_sel,
    input wire logic overtemp_out_first_pin_sel,
    input wire logic overtemp_out_first,
    input wire logic overtemp_out_second
);
    default clocking @(posedge clk);
    endclocking
    default disable iff (!nrst);
    property p_rev; rd && addr == `SPS_IDX_REV |=> rdata == REVISION; endproperty
    a_rev: assert property (p_rev) else $error("revision read wrong");
    property p_irq2; irq2_out |-> system_management_interrupt || $past(system_management_interrupt); endproperty
    a_irq2: assert property (p_irq2) else $error("irq2 without interrupt");
    property p_fan; wr && addr == `SPS_IDX_CFG5 |-> ##2 fan_pin_sel == $past(wdata[1:0], 2); endproperty
    a_fan: assert property (p_fan) else $error("fan select not written");
    property p_bits; disable iff (!nrst || !nbat_rst) wr && addr == `SPS_IDX_PINFN |-> ##2
        {chassis_pin_sel, led_drive_second_pin_sel} == $past({wdata[6], wdata[3]}, 2); endproperty
    a_bits: assert property (p_bits) else $error("single select bits wrong");
    property p_ring; disable iff (!nrst || !nbat_rst) wr && addr == `SPS_IDX_PINFN |-> ##2
        ring_pin_sel == $past(wdata[5:4], 2); endproperty
    a_ring: assert property (p_ring) else $error("ring select wrong");
    property p_pair_sel; led_drive_first_pin_sel == 2'h2 |-> overtemp_out_first_pin_sel; endproperty
    a_pair_sel: assert property (p_pair_sel) else $error("second alarm without first");
    property p_second; overtemp_out_second |-> led_drive_first_pin_sel == 2'h2 || $past(led_drive_first_pin_sel) == 2'h2;
    endproperty
    a_second: assert property (p_second) else $error("second alarm not selected");
    property p_first; !overtemp_out_first_pin_sel && !$past(overtemp_out_first_pin_sel) |-> !overtemp_out_first; endproperty
    a_first: assert property (p_first) else $error("first alarm not selected");
endmodule
bind sps_pin_select sps_pin_select_properties #(.REVISION(REVISION)) u_props (.*);
`default_nettype wire

// ### testbench/sps_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module sps_host_model (
    input wire logic clk,
    output logic [7:0] addr,
    output logic [7:0] wdata,
    output logic wr,
    output logic rd,
    input wire logic [7:0] rdata
);
    initial {addr, wdata, wr, rd} = 18'h00000;
    task automatic wreg(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    // Read data stand only in the cycle after the strobe, so they are taken at that edge.
    task automatic rreg(input logic [7:0] a, output logic [7:0] v);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(posedge clk);
        v = rdata;
    endtask
endmodule
`default_nettype wire

// ### testbench/sps_pin_select_test.sv
`timescale 1ns/1ps
`default_nettype none
`include "sps_defines.svh"
module sps_pin_select_test;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic nbat_rst = 1'b0;
    logic [7:0] src = 8'h00;
    logic [3:0] ot = 4'h0;
    logic [7:0] addr, wdata, rdata, d;
    logic wr, rd, irq, irq2_out, standby_pins_analog, chassis_pin_sel, led_drive_second_pin_sel;
    logic system_management_interrupt, overtemp_out_first_pin_sel, overtemp_out_first, overtemp_out_second;
    logic [1:0] fan_pin_sel, ring_pin_sel, led_drive_first_pin_sel;
    int err_total = 0;
    int samples_checked = 0;
    wire logic [7:0] pins = {standby_pins_analog, chassis_pin_sel, ring_pin_sel,
        led_drive_second_pin_sel, led_drive_first_pin_sel, overtemp_out_first_pin_sel};
    sps_pin_select DUT (.*, .power_control_straps(2'h3), .voltage_monitor(src[7]),
        .temp_event(src[6]), .chassis_intrusion_out(src[5]), .mouse_irq(src[4]),
        .keyboard_irq(src[3]), .keyboard_port_one_line_two(src[2]),
        .general_input_events(src[1]), .watchdog_output(src[0]), .ot_remote_one(ot[3]),
        .ot_remote_two(ot[2]), .ot_local(ot[1]), .ot_voltage(ot[0]));
    sps_host_model host (.*);
    initial begin
        forever #10 clk = ~clk;
    end
    task automatic chk(input logic [7:0] e, input logic [7:0] g);
        samples_checked++;
        if (g !== e) begin
            err_total++;
            $display("[FAIL] t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask
    task automatic rchk(input logic [7:0] a, input logic [7:0] e);
        host.rreg(a, d);
        chk(e, d);
    endtask
    task automatic w(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic pulse(input bit bat);
        @(posedge clk);
        if (bat) nbat_rst <= 1'b0;
        else nrst <= 1'b0;
        w(2);
        @(posedge clk);
        nrst <= 1'b1;
        nbat_rst <= 1'b1;
        w(4);
    endtask
    task automatic t_regs;
        rchk(8'h25, 8'h00);
        rchk(8'h28, 8'h00);
        rchk(8'h2A, 8'h80);
        host.wreg(8'h27, 8'hFE);
        rchk(8'h27, `SPS_REV_DEFAULT);
        rchk(8'h40, 8'h00);
        host.wreg(8'h25, 8'hFF);
        rchk(8'h25, 8'h23);
        chk(8'h03, {6'h00, fan_pin_sel});
        host.wreg(8'h25, 8'h21);
        w(2);
        chk(8'h01, {6'h00, fan_pin_sel});
        $display("t_regs done");
    endtask
    task automatic t_sources;
        for (int i = 0; i < 8; i++) begin
            host.wreg(8'h28, 8'h01 << i);
            @(posedge clk);
            src <= ~(8'h01 << i);
            w(6);
            chk(8'h00, {7'h00, system_management_interrupt});
            @(posedge clk);
            src <= 8'h01 << i;
            w(6);
            chk(8'h01, {7'h00, system_management_interrupt});
            chk(8'h01, {7'h00, irq2_out});
        end
        $display("t_sources done");
    endtask
    task automatic t_irq;
        host.wreg(8'h31, 8'h00);
        @(posedge clk);
        src <= 8'hFF;
        w(6);
        chk(8'h00, {7'h00, irq});
        host.wreg(8'h31, 8'hFF);
        w(3);
        chk(8'h01, {7'h00, irq});
        @(posedge clk);
        src <= 8'h00;
        w(4);
        host.rreg(8'h30, d);
        chk(8'hFF, d);
        w(3);
        chk(8'h00, {7'h00, irq});
        rchk(8'h30, 8'h00);
        rchk(8'h31, 8'hFF);
        $display("t_irq done");
    endtask
    task automatic t_pins;
        host.wreg(8'h2A, 8'hFF);
        rchk(8'h2A, 8'hFF);
        chk(8'hFF, pins);
        pulse(1'b0);
        rchk(8'h2A, 8'hFF);
        pulse(1'b1);
        rchk(8'h2A, 8'h80);
        host.wreg(8'h2A, 8'h04);
        w(2);
        chk(8'h80, pins);
        $display("t_pins done");
    endtask
    task automatic t_overtemp;
        for (int m = 0; m < 2; m++) begin
            host.wreg(8'h2A, m ? 8'h05 : 8'h01);
            for (int i = 0; i < 4; i++) begin
                @(posedge clk);
                ot <= 4'h1 << i;
                w(6);
                d = (m == 1 && i == 2) ? 8'h01 : 8'h02;
                chk(d, {6'h00, overtemp_out_first, overtemp_out_second});
            end
            @(posedge clk);
            ot <= 4'h0;
        end
        $display("t_overtemp done");
    endtask
    task automatic results;
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    initial begin
        repeat (20) @(posedge clk);
        nrst <= 1'b1;
        nbat_rst <= 1'b1;
        w(4);
        t_regs;
        t_sources;
        t_irq;
        t_pins;
        t_overtemp;
        results;
    end
    initial begin
        #100000;
        err_total++;
        results;
    end
endmodule
`default_nettype wire
